// [inc/bdc_defs.svh]
// Constant definitions for the bitmap display controller
`ifndef BDC_DEFS_SVH
`define BDC_DEFS_SVH
// Frame store geometry: four 64K x 4 devices, 16 bits per location
`define BDC_MEM_DEVICES   4
`define BDC_DEV_WIDTH     4
`define BDC_ADDR_W        16
`define BDC_WORD_W        16
// Raster timing in pixel clocks (one pixel per clock)
`define BDC_H_ACTIVE      512
`define BDC_H_FRONT       16
`define BDC_H_SYNC        48
`define BDC_H_BACK        64
`define BDC_V_ACTIVE      256
`define BDC_V_FRONT       4
`define BDC_V_SYNC        4
`define BDC_V_BACK        16
// Counter reset values
`define BDC_CNT_RST       12'h000
// FIFO defaults
`define BDC_FIFO_DEPTH    32
`endif

// [inc/bdc_pkg.sv]
// Types for the bitmap display controller
package bdc_pkg;
  typedef enum logic [1:0] {BDC_IDLE, BDC_WRITE} bdc_wr_state_t;
endpackage

// [src/bdc_fifo.sv]
// Synchronous valid/ready FIFO holding processor write requests
`timescale 1ns/10ps
`include "bdc_defs.svh"
module bdc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = `BDC_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  // Fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    wr_ptr_nxt;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW-1:0]    rd_ptr_nxt;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             push;
  logic             pop;
  logic             in_ready_r;

  // Handshakes; ready is registered so it leaves the top straight from a flop
  assign o_in_ready  = in_ready_r;
  assign o_out_valid = (count_r != '0);
  assign o_out_data  = mem_r[rd_ptr_r];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Pointer and count next state
  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt  = count_r;
    if (push) begin
      wr_ptr_nxt = (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
    end
    if (pop) begin
      rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
    end
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  // Registers; storage has no reset, it is only read when valid
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wr_ptr_r   <= '0;
      rd_ptr_r   <= '0;
      count_r    <= '0;
      in_ready_r <= 1'b1;
    end else begin
      wr_ptr_r   <= wr_ptr_nxt;
      rd_ptr_r   <= rd_ptr_nxt;
      count_r    <= count_nxt;
      in_ready_r <= (count_nxt != (AW+1)'(DEPTH)); // Full is known one cycle ahead
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end
endmodule // bdc_fifo

// [src/bdc_top.sv]
// Bitmap display controller: frame store, scan-out shifter, sync and brightness
//
// Overview of operation
// R1: Processor data bus words are written into the frame store at their address.
// R2: Frame store is four 64K x 4-bit devices, 64K sixteen-bit locations.
// R3: One stored bit drives exactly one pixel; one bit per pixel bitmap.
// R4: Fetched words load a parallel-to-serial shifter emitting one pixel per clock.
// R5: Scan-out repeats forever; writes show on the next refresh pass.
// R6: Horizontal and vertical sync are generated one clock ahead of the pixel stream.
// R7: A brightness select picks full or half intensity for displayed pixels.
// R8: Processor writes wait for free memory slots; refresh fetches always win.
`timescale 1ns/10ps
`include "bdc_defs.svh"
module bdc_top
  import bdc_pkg::*;
#(
  parameter int H_ACTIVE = `BDC_H_ACTIVE,
  parameter int H_FRONT  = `BDC_H_FRONT,
  parameter int H_SYNC   = `BDC_H_SYNC,
  parameter int H_BACK   = `BDC_H_BACK,
  parameter int V_ACTIVE = `BDC_V_ACTIVE,
  parameter int V_FRONT  = `BDC_V_FRONT,
  parameter int V_SYNC   = `BDC_V_SYNC,
  parameter int V_BACK   = `BDC_V_BACK
) (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_reset_n,
  // Processor write port
  input  wire logic                   i_wr_valid,
  output logic                        o_wr_ready,
  input  wire logic [`BDC_ADDR_W-1:0] i_wr_addr,
  input  wire logic [`BDC_WORD_W-1:0] i_wr_data,
  // Brightness select from the processor side
  input  wire logic                   i_half_bright,
  // Display side
  output logic                        o_pixel,
  output logic                        o_full_bright,
  output logic                        o_half_bright,
  output logic                        o_hsync,
  output logic                        o_vsync
);
  localparam int AW     = `BDC_ADDR_W;
  localparam int DW     = `BDC_WORD_W;
  localparam int H_TOT  = H_ACTIVE + H_FRONT + H_SYNC + H_BACK;
  localparam int V_TOT  = V_ACTIVE + V_FRONT + V_SYNC + V_BACK;
  localparam int WPL    = H_ACTIVE / DW;
  localparam int BITW   = $clog2(DW);

  // Frame store built from four 4-bit slices of 64K locations
  logic [`BDC_DEV_WIDTH-1:0] dev_r [`BDC_MEM_DEVICES][2**AW]; // [R2]

  // Write request FIFO
  logic            fifo_valid;
  logic            fifo_ready;
  logic [AW+DW-1:0] fifo_data;

  // Raster counters
  logic [11:0]     hcnt_r;
  logic [11:0]     hcnt_nxt;
  logic [11:0]     vcnt_r;
  logic [11:0]     vcnt_nxt;

  // Fetch and shifter
  logic [AW-1:0]   fetch_addr_r;
  logic [AW-1:0]   fetch_addr_nxt;
  logic [DW-1:0]   fetch_word_r;
  logic [DW-1:0]   shift_r;
  logic [DW-1:0]   shift_nxt;
  logic            fetch_slot;
  logic            load_slot;
  logic            in_vis;
  logic            in_vis_d_r;
  logic            hs_nxt;
  logic            vs_nxt;

  // Write state
  bdc_wr_state_t   wr_state_r;
  bdc_wr_state_t   wr_state_nxt;
  logic            mem_we;

  // Brightness input crosses from a pin: two-flop synchroniser
  logic            hb_meta_r;
  logic            hb_sync_r;

  // Other outputs
  logic            pixel_nxt;

  bdc_fifo #(
    .WIDTH (AW + DW),
    .DEPTH (`BDC_FIFO_DEPTH)
  ) u_wr_fifo (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (i_wr_valid),
    .o_in_ready  (o_wr_ready),
    .i_in_data   ({i_wr_addr, i_wr_data}),
    .o_out_valid (fifo_valid),
    .i_out_ready (fifo_ready),
    .o_out_data  (fifo_data)
  );

  // Raster position; the counters never stop [R5]
  always_comb begin
    hcnt_nxt = hcnt_r + 12'h001;
    vcnt_nxt = vcnt_r;
    if (hcnt_r == 12'(H_TOT - 1)) begin
      hcnt_nxt = `BDC_CNT_RST;
      vcnt_nxt = (vcnt_r == 12'(V_TOT - 1)) ? `BDC_CNT_RST : vcnt_r + 12'h001;
    end
  end

  // Fetch one word in the cycle before each 16-pixel group; load at the group start
  always_comb begin
    in_vis     = (hcnt_r < 12'(H_ACTIVE)) && (vcnt_r < 12'(V_ACTIVE));
    load_slot  = in_vis && (hcnt_r[BITW-1:0] == '0);
    fetch_slot = (vcnt_r < 12'(V_ACTIVE)) && (hcnt_r < 12'(H_ACTIVE))
                 && (hcnt_r[BITW-1:0] == BITW'(DW - 1))
                 && (hcnt_r != 12'(H_ACTIVE - 1));
    fetch_addr_nxt = fetch_addr_r;
    if (hcnt_r == 12'(H_TOT - 1)) begin
      // Prime the first word of the next line
      fetch_slot = (vcnt_nxt < 12'(V_ACTIVE));
    end
    if (fetch_slot) begin
      fetch_addr_nxt = fetch_addr_r + 1'b1;
    end
    if ((hcnt_r == 12'(H_TOT - 1)) && (vcnt_nxt == 12'(V_ACTIVE))) begin
      // Rewind on leaving the visible lines, so the frame prime reads word zero [R5]
      fetch_addr_nxt = '0;
    end
  end

  // Shift register: parallel load, then one bit per clock MSB first [R4]
  always_comb begin
    shift_nxt = {shift_r[DW-2:0], 1'b0};
    if (load_slot) begin
      shift_nxt = fetch_word_r; // [R4]
    end
    pixel_nxt = in_vis_d_r ? shift_r[DW-1] : 1'b0; // one bit, one pixel [R3]
  end

  // Sync pulses placed relative to the pixel count, registered once, one clock ahead of the two-register pixel path
  always_comb begin
    hs_nxt = (hcnt_r >= 12'(H_ACTIVE + H_FRONT))
             && (hcnt_r < 12'(H_ACTIVE + H_FRONT + H_SYNC)); // [R6]
    vs_nxt = (vcnt_r >= 12'(V_ACTIVE + V_FRONT))
             && (vcnt_r < 12'(V_ACTIVE + V_FRONT + V_SYNC)); // [R6]
  end

  // Processor writes use only cycles that carry no refresh fetch [R8]
  always_comb begin
    wr_state_nxt = wr_state_r;
    mem_we       = 1'b0;
    fifo_ready   = 1'b0;
    unique case (wr_state_r)
      BDC_IDLE: begin
        if (fifo_valid) begin
          wr_state_nxt = BDC_WRITE;
        end
      end
      BDC_WRITE: begin
        if (!fetch_slot) begin
          mem_we       = 1'b1; // [R1]
          fifo_ready   = 1'b1;
          wr_state_nxt = BDC_IDLE;
        end
      end
    endcase
  end

  // Frame store write; each device takes its own nibble [R1]
  always_ff @(posedge i_clk) begin
    if (mem_we) begin
      for (int d = 0; d < `BDC_MEM_DEVICES; d++) begin
        dev_r[d][fifo_data[AW+DW-1:DW]] <= fifo_data[d*`BDC_DEV_WIDTH +: `BDC_DEV_WIDTH];
      end
    end
  end

  // Refresh read; never blocked by a write [R8]
  // Cleared at reset so the unprimed first 16-pixel group after reset shows dark, not unknown
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      fetch_word_r <= '0;
    end else if (fetch_slot) begin
      for (int d = 0; d < `BDC_MEM_DEVICES; d++) begin
        fetch_word_r[d*`BDC_DEV_WIDTH +: `BDC_DEV_WIDTH] <= dev_r[d][fetch_addr_r];
      end
    end
  end

  // Synchroniser for the brightness select
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      hb_meta_r <= 1'b0;
      hb_sync_r <= 1'b0;
    end else begin
      hb_meta_r <= i_half_bright;
      hb_sync_r <= hb_meta_r;
    end
  end

  // Control and output registers
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      hcnt_r        <= `BDC_CNT_RST;
      vcnt_r        <= `BDC_CNT_RST;
      fetch_addr_r  <= '0;
      shift_r       <= '0;
      in_vis_d_r    <= 1'b0;
      wr_state_r    <= BDC_IDLE;
      o_pixel       <= 1'b0;
      o_hsync       <= 1'b0;
      o_vsync       <= 1'b0;
      o_full_bright <= 1'b0;
      o_half_bright <= 1'b0;
    end else begin
      hcnt_r        <= hcnt_nxt;
      vcnt_r        <= vcnt_nxt;
      fetch_addr_r  <= fetch_addr_nxt;
      shift_r       <= shift_nxt;
      in_vis_d_r    <= in_vis;
      wr_state_r    <= wr_state_nxt;
      o_pixel       <= pixel_nxt;
      o_hsync       <= hs_nxt;
      o_vsync       <= vs_nxt;
      // Exactly one brightness line is active while pixels show [R7]
      o_full_bright <= pixel_nxt && !hb_sync_r;
      o_half_bright <= pixel_nxt && hb_sync_r;
    end
  end
endmodule // bdc_top

// [verif/bdc_top_asserts.sv]
// Port checker for the bitmap display controller
`timescale 1ns/10ps
`include "bdc_defs.svh"
module bdc_top_asserts #(
  parameter int H_ACTIVE = `BDC_H_ACTIVE,
  parameter int H_FRONT  = `BDC_H_FRONT,
  parameter int H_SYNC   = `BDC_H_SYNC,
  parameter int H_BACK   = `BDC_H_BACK,
  parameter int V_ACTIVE = `BDC_V_ACTIVE,
  parameter int V_FRONT  = `BDC_V_FRONT,
  parameter int V_SYNC   = `BDC_V_SYNC,
  parameter int V_BACK   = `BDC_V_BACK
) (
  // Clock, reset and write handshake
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_wr_valid,
  input wire logic o_wr_ready,
  // Display side
  input wire logic o_pixel,
  input wire logic o_full_bright,
  input wire logic o_half_bright,
  input wire logic o_hsync,
  input wire logic o_vsync
);
  // Raster spans; whole frame must stay short in test builds
  localparam int HT = H_ACTIVE + H_FRONT + H_SYNC + H_BACK;
  localparam int FR = HT * (V_ACTIVE + V_FRONT + V_SYNC + V_BACK);
  localparam int VS = HT * V_SYNC;
  localparam int HA = H_ACTIVE + H_FRONT;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_next_line;
    ##HT $rose(o_hsync);
  endsequence
  property p_hs_per; $rose(o_hsync) |-> s_next_line; endproperty
  property p_hs_len; $rose(o_hsync) |-> ##H_SYNC $fell(o_hsync); endproperty
  property p_vs_len; $rose(o_vsync) |-> ##VS $fell(o_vsync); endproperty
  property p_vs_per; $rose(o_vsync) |-> ##FR $rose(o_vsync); endproperty
  property p_vs_hs; $rose(o_vsync) |-> ##HA $rose(o_hsync); endproperty
  property p_bright;
    o_pixel == (o_full_bright || o_half_bright) && !(o_full_bright && o_half_bright);
  endproperty
  property p_hblank; o_hsync |-> !o_pixel; endproperty
  property p_vblank; o_vsync |-> !o_pixel; endproperty
  property p_drain; !o_wr_ready |-> ##[1:8] o_wr_ready; endproperty
  property p_hold; o_wr_ready && !i_wr_valid |=> o_wr_ready; endproperty
  a_hs_per: assert property (p_hs_per) else $error("line period off");
  a_hs_len: assert property (p_hs_len) else $error("hsync width off");
  a_vs_len: assert property (p_vs_len) else $error("vsync width off");
  a_vs_per: assert property (p_vs_per) else $error("frame period off");
  a_vs_hs: assert property (p_vs_hs) else $error("vsync to hsync off");
  a_bright: assert property (p_bright) else $error("brightness bad");
  a_hblank: assert property (p_hblank) else $error("pixel in hsync");
  a_vblank: assert property (p_vblank) else $error("pixel in vsync");
  a_drain: assert property (p_drain) else $error("queue stuck");
  a_hold: assert property (p_hold) else $error("ready fell idle");
endmodule // bdc_top_asserts
bind bdc_top bdc_top_asserts #(.H_ACTIVE(H_ACTIVE), .H_FRONT(H_FRONT), .H_SYNC(H_SYNC),
  .H_BACK(H_BACK), .V_ACTIVE(V_ACTIVE), .V_FRONT(V_FRONT), .V_SYNC(V_SYNC),
  .V_BACK(V_BACK)) u_bdc_top_asserts (.i_clk, .i_reset_n, .i_wr_valid, .o_wr_ready,
  .o_pixel, .o_full_bright, .o_half_bright, .o_hsync, .o_vsync);

// [verif/bdc_monitor.sv]
// Raster monitor model capturing pixels of one frame
`timescale 1ns/10ps
module bdc_monitor #(
  parameter int W = 32,
  parameter int L = 4
) (
  // Clock
  input wire logic i_clk,
  // Display link
  input wire logic i_pixel,
  input wire logic i_full,
  input wire logic i_half,
  input wire logic i_hsync,
  input wire logic i_vsync
);
  logic hs_q   = 1'b0;
  logic vs_q   = 1'b0;
  int   col    = W;
  int   ln     = L;
  int   frames = 0;
  int   n_full = 0;
  int   n_half = 0;
  logic fb [0:L-1][0:W-1];
  // Lines are placed by sync edges only, as a real monitor
  always @(posedge i_clk) begin
    hs_q <= i_hsync;
    vs_q <= i_vsync;
    col <= col + 1;
    if (vs_q && !i_vsync) begin
      ln <= -1;
      n_full <= 0;
      n_half <= 0;
    end else if (i_hsync && !hs_q) begin
      ln <= ln + 1;
      col <= -6;
    end
    // One serial bit per screen position
    if (col >= 0 && col < W && ln >= 0 && ln < L) begin
      fb[ln][col] <= i_pixel;
      n_full <= n_full + int'(i_full);
      n_half <= n_half + int'(i_half);
      if (ln == L - 1 && col == W - 1) frames <= frames + 1;
    end
  end
endmodule // bdc_monitor

// [verif/bdc_top_tb.sv]
// Self-checking testbench for the bitmap display controller
`timescale 1ns/10ps
module bdc_top_tb;
  logic        i_clk, i_reset_n, i_wr_valid, i_half_bright;
  logic [15:0] i_wr_addr, i_wr_data;
  logic        o_wr_ready, o_pixel, o_full_bright, o_half_bright, o_hsync, o_vsync;
  logic [15:0] m [0:7];
  int          errors, n_checks;
  logic        half, refused;
  // Small raster: 40 clocks a line, 7 lines a frame
  localparam int TB_HA = 32;
  localparam int TB_HF = 2;
  localparam int TB_HS = 4;
  localparam int TB_HB = 2;
  localparam int TB_VA = 4;
  localparam int TB_VF = 1;
  localparam int TB_VS = 1;
  localparam int TB_VB = 1;
  bdc_top #(.H_ACTIVE(TB_HA), .H_FRONT(TB_HF), .H_SYNC(TB_HS), .H_BACK(TB_HB),
    .V_ACTIVE(TB_VA), .V_FRONT(TB_VF), .V_SYNC(TB_VS), .V_BACK(TB_VB)) u_bdc_top (.i_clk,
    .i_reset_n, .i_wr_valid, .o_wr_ready, .i_wr_addr, .i_wr_data, .i_half_bright, .o_pixel,
    .o_full_bright, .o_half_bright, .o_hsync, .o_vsync);
  bdc_monitor #(.W(TB_HA), .L(TB_VA)) u_bdc_monitor (.i_clk, .i_pixel(o_pixel),
    .i_full(o_full_bright),
    .i_half(o_half_bright), .i_hsync(o_hsync), .i_vsync(o_vsync));
  task chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Valid is left high so writes can run back to back
  task wr(input logic [15:0] a, d);
    i_wr_addr = a;
    i_wr_data = d;
    i_wr_valid = 1'b1;
    for (int k = 0; o_wr_ready !== 1'b1 && k < 100; k++) begin
      refused = 1'b1;
      @(posedge i_clk);
      #1;
    end
    chk(o_wr_ready, 1'b1);
    @(posedge i_clk);
    #1;
    if (a < 16'h0008) m[a[2:0]] = d;
  endtask
  // Two frame ends, so the later one started after all writes
  task cmp_frame;
    int f, ones;
    logic b;
    f = u_bdc_monitor.frames;
    for (int k = 0; u_bdc_monitor.frames < f + 2 && k < 1000; k++) @(posedge i_clk);
    #1;
    chk(32'(u_bdc_monitor.frames >= f + 2), 32'h1);
    ones = 0;
    for (int l = 0; l < 4; l++)
      for (int c = 0; c < 32; c++) begin
        b = m[l * 2 + c / 16][15 - c % 16];
        ones += int'(b);
        chk(u_bdc_monitor.fb[l][c], b);
      end
    chk(u_bdc_monitor.n_full, half ? 0 : ones);
    chk(u_bdc_monitor.n_half, half ? ones : 0);
  endtask
  task t_fill;
    for (int i = 0; i < 8; i++) wr(16'(i), 16'h8001 ^ 16'(i * 16'h1357));
    i_wr_valid = 1'b0;
    cmp_frame;
  endtask
  task t_half;
    half = 1'b1;
    i_half_bright = 1'b1;
    wr(16'h0003, 16'hFFFF);
    wr(16'h0004, 16'h0000);
    i_wr_valid = 1'b0;
    cmp_frame;
  endtask
  // Flood to the top of memory while refresh runs
  task t_flood;
    refused = 1'b0;
    half = 1'b0;
    i_half_bright = 1'b0;
    for (int i = 0; i < 80; i++) wr(16'hFFB0 + 16'(i), 16'h0F0F);
    wr(16'h0000, 16'h1234);
    i_wr_valid = 1'b0;
    chk(refused, 1'b1);
    cmp_frame;
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    #100000;
    errors++;
    report_and_stop;
  end
  initial begin
    {i_reset_n, i_wr_valid, i_half_bright, half} = 4'h0;
    {i_wr_addr, i_wr_data} = 32'h0;
    {errors, n_checks} = 0;
    repeat (5) @(posedge i_clk);
    #1;
    i_reset_n = 1'b1;
    t_fill;
    t_half;
    t_flood;
    report_and_stop;
  end
endmodule // bdc_top_tb
